// ### hw/bfs_pkg.sv
// Package of constants and carrier types for the backlight fault supervisor.
package bfs_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  localparam logic [7:0] ADDR_CONFIG = 8'h10;

  // ****************************************
  // Status bit positions
  // ****************************************
  localparam int NUM_FLAGS = 14;
  localparam int B_IN_LOW = 0;
  localparam int B_IN_HIGH = 1;
  localparam int B_CORE_LOW = 2;
  localparam int B_IN_OC = 3;
  localparam int B_CP = 4;
  localparam int B_CP_PART = 5;
  localparam int B_CLK_LOST = 6;
  localparam int B_CRC = 7;
  localparam int B_OV_LOW = 8;
  localparam int B_OV_HIGH = 9;
  localparam int B_BST_OC = 10;
  localparam int B_STR_RES = 11;
  localparam int B_MODE_RES = 12;
  localparam int B_FREQ_RES = 13;

  // Flags that are allowed to raise the fault interrupt.
  localparam logic [13:0] IRQ_CAPABLE = 14'h06FF;
  localparam logic [13:0] MASK_RESET = 14'h3FFF;

  // ****************************************
  // Fallback configuration values
  // ****************************************
  localparam logic [2:0] DEF_CHANNELS = 3'h4;
  localparam logic [7:0] DEF_CURRENT_MA = 8'hC8;
  localparam logic [6:0] DEF_I2C_ADDR = 7'h3A;
  localparam logic DEF_MODE_PHASE_SHIFT = 1'b0;
  localparam logic [11:0] DEF_BOOST_KHZ = 12'h190;
  localparam logic [11:0] DEF_PWM_HZ = 12'h131;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int RECOVERY_MS = 100;
  localparam int BST_OC_MS = 110;
  localparam int RECOVERY_CYCLES = CLK_HZ / 1000 * RECOVERY_MS;
  localparam int BST_OC_CYCLES = CLK_HZ / 1000 * BST_OC_MS;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_STANDBY,
    ST_RUN,
    ST_RECOVERY
  } bfs_state_e;

  // Comparator and detector inputs gathered as one carrier.
  typedef struct packed {
    logic in_low;
    logic in_high;
    logic core_low;
    logic in_oc;
    logic cp_bad;
    logic cp_part_missing;
    logic clk_lost;
    logic crc_error;
    logic ov_low;
    logic ov_high;
    logic fb_under;
  } bfs_sense_s;

  // Resistor detection result captured during initialization.
  typedef struct packed {
    logic str_bad;
    logic mode_bad;
    logic freq_bad;
    logic [2:0] channels;
    logic [7:0] current_ma;
    logic mode_sel;
    logic [6:0] i2c_addr;
    logic [11:0] boost_khz;
    logic [11:0] pwm_hz;
  } bfs_cfg_s;

endpackage : bfs_pkg

// ### hw/bfs_timer.sv
// Up counter used for the recovery hold and the boost under-voltage timer.
`timescale 1ns/1ps
`default_nettype none
module bfs_timer #(
  parameter int CYCLES = 1_000_000
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic run_in,
  output logic done_out
);

  localparam int W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [W-1:0] count;
    logic done;
  } bfs_timer_s;

  bfs_timer_s st;
  bfs_timer_s next_st;

  initial begin
    if (CYCLES < 2) begin
      $error("bfs_timer needs at least two cycles");
    end
  end

  // Count up while run is held; a drop of run restarts the measure.
  always_comb begin
    next_st = st;
    if (!run_in) begin
      next_st.count = '0;
      next_st.done = 1'b0;
    end else if (st.count != W'(CYCLES - 1)) begin
      next_st.count = st.count + W'(1);
    end else begin
      next_st.done = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done_out = st.done;

endmodule : bfs_timer
`default_nettype wire

// ### hw/bfs_cfg_latch.sv
// Initialization-time resistor check with fallback configuration.
`timescale 1ns/1ps
`default_nettype none
module bfs_cfg_latch (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic capture_in,
  input wire logic str_valid_in,
  input wire logic [2:0] str_channels_in,
  input wire logic [7:0] str_current_in,
  input wire logic mode_valid_in,
  input wire logic mode_sel_in,
  input wire logic [6:0] mode_addr_in,
  input wire logic boost_freq_valid_in,
  input wire logic [11:0] boost_freq_in,
  input wire logic dimming_freq_valid_in,
  input wire logic [11:0] dimming_freq_in,
  output bfs_pkg::bfs_cfg_s cfg_out
);

  bfs_pkg::bfs_cfg_s st;
  bfs_pkg::bfs_cfg_s next_st;

  // Resistors are only looked at on capture; later changes are ignored.
  always_comb begin
    next_st = st;
    if (capture_in) begin
      next_st.str_bad = !str_valid_in;
      next_st.channels = str_valid_in ? str_channels_in : bfs_pkg::DEF_CHANNELS;
      next_st.current_ma = str_valid_in ? str_current_in : bfs_pkg::DEF_CURRENT_MA;
      next_st.mode_bad = !mode_valid_in;
      next_st.mode_sel = mode_valid_in ? mode_sel_in : bfs_pkg::DEF_MODE_PHASE_SHIFT;
      next_st.i2c_addr = mode_valid_in ? mode_addr_in : bfs_pkg::DEF_I2C_ADDR;
      next_st.freq_bad = !(boost_freq_valid_in && dimming_freq_valid_in);
      next_st.boost_khz = boost_freq_valid_in ? boost_freq_in : bfs_pkg::DEF_BOOST_KHZ;
      next_st.pwm_hz = dimming_freq_valid_in ? dimming_freq_in : bfs_pkg::DEF_PWM_HZ;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st <= '{default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign cfg_out = st;

endmodule : bfs_cfg_latch
`default_nettype wire

// ### hw/bfs_supervisor.sv
// Top of the backlight fault supervisor with its Wishbone register slave.
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Input below lockout level: flag, interrupt, standby until input recovers.
// - Input above over-voltage level: flag, interrupt, standby until it falls.
// - Core supply low: flag, interrupt, no recovery, restart when supply returns.
// - Input over-current: flag, interrupt, recovery, restart 100 ms later.
// - Charge pump abnormal: flag, interrupt, recovery then restart after delay.
// - Pump parts missing: flag, interrupt, pump off, pump fault flagged, keep running.
// - Sync clock lost after valid start: flag, interrupt, use internal clock.
// - After fallback, sync input high enables spread spectrum, low disables it.
// - Defaults load check error: flag, interrupt, keep running.
// - Low boost over-voltage: flag only, boost pauses, stay in normal mode.
// - High boost over-voltage: flag, interrupt, recovery until output falls.
// - Feedback under level for 110 ms: flag, interrupt, recovery, restart 100 ms.
// - Bad string resistor: flag only, default four channels at 200 mA.
// - Bad mode resistor: flag only, default phase-shift mode, address 0x3A.
// - Bad frequency resistor: flag only, default 400 kHz boost, 305 Hz dimming.
// - Recovery keeps drivers off 100 ms, restarts if enabled and brightness set.
// - Resistors checked only at initialization; chosen configuration is kept.
module bfs_supervisor #(
  parameter int RECOVERY_CYCLES = bfs_pkg::RECOVERY_CYCLES,
  parameter int BST_OC_CYCLES = bfs_pkg::BST_OC_CYCLES
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire bfs_pkg::bfs_sense_s sense_in,
  input wire logic boost_clock_sync_input,
  input wire logic enable_in,
  input wire logic brightness_nonzero_in,
  input wire logic init_done_in,
  input wire logic str_valid_in,
  input wire logic [2:0] str_channels_in,
  input wire logic [7:0] str_current_in,
  input wire logic mode_valid_in,
  input wire logic mode_sel_in,
  input wire logic [6:0] mode_addr_in,
  input wire logic boost_freq_valid_in,
  input wire logic [11:0] boost_freq_in,
  input wire logic dimming_freq_valid_in,
  input wire logic [11:0] dimming_freq_in,
  output logic irq_out,
  output logic power_on_out,
  output logic boost_switch_out,
  output logic charge_pump_on_out,
  output logic internal_clock_out,
  output logic spread_spectrum_out,
  output bfs_pkg::bfs_cfg_s cfg_out
);

  initial begin
    if (RECOVERY_CYCLES < 2 || BST_OC_CYCLES < 2) begin
      $error("bfs_supervisor timer counts must be at least two");
    end
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    bfs_pkg::bfs_state_e fsm;
    logic [13:0] status;
    logic [13:0] mask;
    logic cp_disabled;
    logic clk_fallback;
    logic sync_seen;
    logic hold_restart;
    logic [31:0] rdata;
    logic ack;
    logic irq;
    logic power_on;
    logic boost_sw;
    logic cp_on;
    logic ss_on;
    bfs_pkg::bfs_cfg_s cfg;
  } bfs_top_s;

  bfs_top_s st;
  bfs_top_s next_st;
  bfs_pkg::bfs_cfg_s cfg_now;
  logic rec_done;
  logic fb_timeout;

  // Capture happens once when initialization completes.
  bfs_cfg_latch u_cfg (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .capture_in(st.fsm == bfs_pkg::ST_INIT && init_done_in),
    .str_valid_in(str_valid_in),
    .str_channels_in(str_channels_in),
    .str_current_in(str_current_in),
    .mode_valid_in(mode_valid_in),
    .mode_sel_in(mode_sel_in),
    .mode_addr_in(mode_addr_in),
    .boost_freq_valid_in(boost_freq_valid_in),
    .boost_freq_in(boost_freq_in),
    .dimming_freq_valid_in(dimming_freq_valid_in),
    .dimming_freq_in(dimming_freq_in),
    .cfg_out(cfg_now)
  );

  // Recovery hold timer runs for the whole stay in recovery.
  bfs_timer #(.CYCLES(RECOVERY_CYCLES)) u_rec (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .run_in(st.fsm == bfs_pkg::ST_RECOVERY),
    .done_out(rec_done)
  );

  // Feedback under-level timer is only meaningful while the boost runs.
  bfs_timer #(.CYCLES(BST_OC_CYCLES)) u_fb (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .run_in(st.fsm == bfs_pkg::ST_RUN && sense_in.fb_under),
    .done_out(fb_timeout)
  );

  // Keep the register data aligned to the flag width.
  function automatic logic [31:0] widen(input logic [13:0] v);
    widen = {18'h0_0000, v};
  endfunction : widen

  // ****************************************
  // Next-state logic
  // ****************************************
  logic [13:0] events;
  logic recover_now;
  logic standby_now;
  logic rd_hit;
  logic wr_hit;

  always_comb begin
    next_st = st;
    events = '0;
    events[bfs_pkg::B_IN_LOW] = sense_in.in_low;
    events[bfs_pkg::B_IN_HIGH] = sense_in.in_high;
    events[bfs_pkg::B_CORE_LOW] = sense_in.core_low;
    events[bfs_pkg::B_IN_OC] = sense_in.in_oc;
    events[bfs_pkg::B_CP] = sense_in.cp_bad || sense_in.cp_part_missing;
    events[bfs_pkg::B_CP_PART] = sense_in.cp_part_missing;
    // Loss only counts once a valid external clock was seen at start.
    events[bfs_pkg::B_CLK_LOST] = st.sync_seen && sense_in.clk_lost;
    events[bfs_pkg::B_CRC] = sense_in.crc_error;
    events[bfs_pkg::B_OV_LOW] = sense_in.ov_low;
    events[bfs_pkg::B_OV_HIGH] = sense_in.ov_high;
    events[bfs_pkg::B_BST_OC] = fb_timeout;
    if (st.fsm == bfs_pkg::ST_INIT && init_done_in) begin
      events[bfs_pkg::B_STR_RES] = !str_valid_in;
      events[bfs_pkg::B_MODE_RES] = !mode_valid_in;
      events[bfs_pkg::B_FREQ_RES] = !(boost_freq_valid_in && dimming_freq_valid_in);
    end
    rd_hit = wb_cyc_in && wb_stb_in && !st.ack && !wb_we_in;
    wr_hit = wb_cyc_in && wb_stb_in && !st.ack && wb_we_in;

    // A status read clears flags, but a new event in that cycle wins.
    if (rd_hit && wb_adr_in == bfs_pkg::ADDR_STATUS) begin
      next_st.status = events;
    end else begin
      next_st.status = st.status | events;
    end
    if (wr_hit && wb_adr_in == bfs_pkg::ADDR_MASK && wb_sel_in[0]) begin
      next_st.mask[7:0] = wb_dat_in[7:0];
    end
    if (wr_hit && wb_adr_in == bfs_pkg::ADDR_MASK && wb_sel_in[1]) begin
      next_st.mask[13:8] = wb_dat_in[13:8];
    end

    // Read mux and single-cycle ack.
    next_st.ack = wb_cyc_in && wb_stb_in && !st.ack;
    next_st.rdata = 32'h0000_0000;
    if (rd_hit) begin
      case (wb_adr_in)
        bfs_pkg::ADDR_STATUS: next_st.rdata = widen(st.status);
        bfs_pkg::ADDR_MASK: next_st.rdata = widen(st.mask);
        bfs_pkg::ADDR_CTRL: next_st.rdata = {28'h000_0000, st.ss_on, st.clk_fallback,
                                             st.cp_disabled, st.boost_sw};
        bfs_pkg::ADDR_STATE: next_st.rdata = {29'h0000_0000, st.fsm};
        bfs_pkg::ADDR_CONFIG: next_st.rdata = {5'h00, cfg_now.channels, cfg_now.current_ma,
                                               cfg_now.mode_sel, cfg_now.i2c_addr,
                                               cfg_now.boost_khz[7:0]};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end

    // Faults that force standby or recovery.
    standby_now = sense_in.in_low || sense_in.in_high || sense_in.core_low;
    recover_now = sense_in.in_oc || sense_in.cp_bad || sense_in.ov_high || fb_timeout;

    // Pump parts missing turns the pump off for good but never stops the device.
    if (sense_in.cp_part_missing) begin
      next_st.cp_disabled = 1'b1;
    end
    if (events[bfs_pkg::B_CLK_LOST]) begin
      next_st.clk_fallback = 1'b1;
    end

    case (st.fsm)
      bfs_pkg::ST_INIT: begin
        if (init_done_in) begin
          next_st.fsm = bfs_pkg::ST_STANDBY;
          next_st.sync_seen = !sense_in.clk_lost;
        end
      end
      bfs_pkg::ST_STANDBY: begin
        if (!standby_now && enable_in && brightness_nonzero_in && !st.hold_restart) begin
          next_st.fsm = bfs_pkg::ST_RUN;
        end
        // Over-voltage high waits for the output to fall before a restart.
        next_st.hold_restart = sense_in.ov_high;
      end
      bfs_pkg::ST_RUN: begin
        if (standby_now) begin
          next_st.fsm = bfs_pkg::ST_STANDBY;
        end else if (recover_now) begin
          next_st.fsm = bfs_pkg::ST_RECOVERY;
        end else if (!enable_in) begin
          next_st.fsm = bfs_pkg::ST_STANDBY;
        end
      end
      bfs_pkg::ST_RECOVERY: begin
        if (rec_done) begin
          next_st.fsm = bfs_pkg::ST_STANDBY;
          next_st.hold_restart = sense_in.ov_high;
        end
      end
      default: next_st.fsm = bfs_pkg::ST_INIT;
    endcase

    // Outputs registered from the coming state.
    next_st.power_on = next_st.fsm == bfs_pkg::ST_RUN;
    // Low over-voltage pauses switching only; power stays on.
    next_st.boost_sw = next_st.power_on && !sense_in.ov_low;
    next_st.cp_on = next_st.power_on && !next_st.cp_disabled;
    next_st.ss_on = next_st.clk_fallback && boost_clock_sync_input;
    next_st.irq = |(next_st.status & next_st.mask & bfs_pkg::IRQ_CAPABLE);
    next_st.cfg = cfg_now;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st <= '{fsm: bfs_pkg::ST_INIT, mask: bfs_pkg::MASK_RESET, cfg: '{default: '0},
              default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_out = st.rdata;
  assign wb_ack_out = st.ack;
  assign irq_out = st.irq;
  assign power_on_out = st.power_on;
  assign boost_switch_out = st.boost_sw;
  assign charge_pump_on_out = st.cp_on;
  assign internal_clock_out = st.clk_fallback;
  assign spread_spectrum_out = st.ss_on;
  assign cfg_out = st.cfg;

  // ****************************************
  // Checks
  // ****************************************
  a_undervolt_standby: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st.fsm == bfs_pkg::ST_RUN && sense_in.in_low |=> st.fsm == bfs_pkg::ST_STANDBY)
    else $error("input lockout did not force standby");
  a_overvolt_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    sense_in.in_high |=> st.status[bfs_pkg::B_IN_HIGH])
    else $error("input over-voltage flag not set");
  a_core_no_recovery: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st.fsm != bfs_pkg::ST_RECOVERY && sense_in.core_low && !recover_now
    |=> st.fsm != bfs_pkg::ST_RECOVERY)
    else $error("core supply low entered recovery");
  a_overcurrent_recover: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st.fsm == bfs_pkg::ST_RUN && !standby_now && sense_in.in_oc
    |=> st.fsm == bfs_pkg::ST_RECOVERY)
    else $error("input over-current did not enter recovery");
  a_pump_missing_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    sense_in.cp_part_missing |=> !st.cp_on && st.status[bfs_pkg::B_CP])
    else $error("charge pump not disabled on missing parts");
  a_spread_follows: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st.clk_fallback && $stable(boost_clock_sync_input) |=> st.ss_on == $past(boost_clock_sync_input))
    else $error("spread spectrum does not follow sync input");
  a_ovlow_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st.fsm == bfs_pkg::ST_RUN && sense_in.ov_low |=> !st.boost_sw)
    else $error("boost kept switching under low over-voltage");
  a_recovery_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st.fsm == bfs_pkg::ST_RECOVERY |-> !st.power_on && !st.boost_sw)
    else $error("power on during recovery");
  a_irq_level: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st.irq == |(st.status & st.mask & bfs_pkg::IRQ_CAPABLE))
    else $error("interrupt level mismatch");
  a_resistor_no_irq: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (st.status & bfs_pkg::IRQ_CAPABLE) == 14'h0000 |-> !st.irq)
    else $error("resistor flag raised the interrupt");

endmodule : bfs_supervisor
`default_nettype wire

// ### verification/bfs_host_model.sv
// Host controller model that services the fault interrupt over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module bfs_host_model (
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic [31:0] dat_in,
  output logic cyc_out,
  output logic stb_out,
  output logic we_out,
  output logic [7:0] adr_out,
  output logic [3:0] sel_out,
  output logic [31:0] dat_out
);
  // ****************************************
  // Bus cycles
  // ****************************************
  // The bus idles with every request line low.
  initial begin
    cyc_out = 1'b0;
    stb_out = 1'b0;
    we_out = 1'b0;
    adr_out = 8'h00;
    sel_out = 4'h0;
    dat_out = 32'h0000_0000;
  end

  // One classic cycle; the request stays put until ack is seen at an edge, for at most 20 edges.
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
    int n;
    @(posedge clk_in);
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out <= we;
    adr_out <= adr;
    sel_out <= 4'hF;
    dat_out <= wd;
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge clk_in);
      ok = (ack_in === 1'b1);
    end
    rd = dat_in;
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    we_out <= 1'b0;
  endtask : xfer

  // Interrupt service: fetching the flags also clears them.
  task automatic service(output logic [31:0] flags, output logic ok);
    xfer(1'b0, bfs_pkg::ADDR_STATUS, 32'h0000_0000, flags, ok);
  endtask : service
endmodule : bfs_host_model
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the backlight fault supervisor.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Short recovery and under-level counts keep the run brief.
  localparam int RCY = 20;
  localparam int BOC = 30;
  logic clk_in, sys_rst_in, cyc, stb, we, ack, sync_in, en, bright, init_done;
  logic irq, pwr, bsw, cpo, iclk, ss, sv, mv, bv, dv, msel;
  logic [3:0] sel;
  logic [7:0] adr, scur;
  logic [31:0] dw, dr;
  logic [2:0] sch;
  logic [6:0] madr;
  logic [11:0] bf, df;
  bfs_pkg::bfs_sense_s sense;
  bfs_pkg::bfs_cfg_s cfg, ecfg;
  int err_total = 0;
  int compares = 0;

  bfs_supervisor #(.RECOVERY_CYCLES(RCY), .BST_OC_CYCLES(BOC)) uut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dw), .wb_dat_out(dr),
    .wb_ack_out(ack), .sense_in(sense), .boost_clock_sync_input(sync_in), .enable_in(en),
    .brightness_nonzero_in(bright), .init_done_in(init_done), .str_valid_in(sv),
    .str_channels_in(sch), .str_current_in(scur), .mode_valid_in(mv), .mode_sel_in(msel),
    .mode_addr_in(madr), .boost_freq_valid_in(bv), .boost_freq_in(bf),
    .dimming_freq_valid_in(dv), .dimming_freq_in(df), .irq_out(irq), .power_on_out(pwr),
    .boost_switch_out(bsw), .charge_pump_on_out(cpo), .internal_clock_out(iclk),
    .spread_spectrum_out(ss), .cfg_out(cfg));

  bfs_host_model host (.clk_in(clk_in), .ack_in(ack), .dat_in(dr), .cyc_out(cyc),
    .stb_out(stb), .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(dw));

  // ****************************************
  // Helpers
  // ****************************************
  // The clock runs at 10 MHz.
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick

  // Verdict; a bus or wait timeout also ends up here.
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  // A bus cycle that never gets its ack counts as a mismatch and stops the run.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    logic ok;
    host.xfer(w, a, wd, d, ok);
    if (!ok) begin
      err_total++;
      summarize();
    end
  endtask : bus

  task automatic wait_pwr(input logic v);
    int n;
    for (n = 0; n < 300 && pwr !== v; n++) tick(1);
    chk("power_on", v, pwr);
    if (pwr !== v) summarize();
  endtask : wait_pwr

  // ****************************************
  // Scenarios
  // ****************************************
  // Reset values and an unmapped place, which reads zero and ignores writes.
  task automatic t_reset();
    logic [31:0] d;
    bus(1'b0, bfs_pkg::ADDR_MASK, '0, d);
    chk("mask", 32'h0000_3FFF, d);
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF, d);
    bus(1'b0, 8'h1C, '0, d);
    chk("unmapped", 32'h0000_0000, d);
    chk("irq", 1'b0, irq);
  endtask : t_reset

  // Bad resistors at init give fallbacks that later pin changes cannot alter.
  task automatic t_init();
    logic [31:0] d;
    ecfg = '{str_bad:1'b1, mode_bad:1'b1, freq_bad:1'b1, channels:3'h4, current_ma:8'hC8,
             mode_sel:1'b0, i2c_addr:7'h3A, boost_khz:12'h190, pwm_hz:12'h131};
    init_done <= 1'b1;
    tick(4);
    chk("cfg", ecfg, cfg);
    chk("irq", 1'b0, irq);
    sv <= 1'b1;
    mv <= 1'b1;
    bv <= 1'b1;
    dv <= 1'b1;
    tick(4);
    chk("cfg kept", ecfg, cfg);
    bus(1'b0, bfs_pkg::ADDR_STATUS, '0, d);
    chk("status", 32'h0000_3800, d);
    bus(1'b0, bfs_pkg::ADDR_CONFIG, '0, d);
    chk("config", 32'h04C8_3A90, d);
    en <= 1'b1;
    bright <= 1'b1;
    wait_pwr(1'b1);
  endtask : t_init

  // A standby fault keeps power off for as long as the fault stays.
  task automatic t_standby(input int sb, input int fb);
    logic [31:0] d;
    sense[sb] <= 1'b1;
    wait_pwr(1'b0);
    tick(RCY + 10);
    chk("held off", 1'b0, pwr);
    chk("irq", 1'b1, irq);
    bus(1'b0, bfs_pkg::ADDR_STATE, '0, d);
    chk("state", {29'h0, bfs_pkg::ST_STANDBY}, d);
    sense[sb] <= 1'b0;
    wait_pwr(1'b1);
    bus(1'b0, bfs_pkg::ADDR_STATUS, '0, d);
    chk("status", 32'h1 << fb, d);
    tick(3);
    chk("irq released", 1'b0, irq);
  endtask : t_standby

  // A recovery fault held h cycles; restart needs the hold over and brightness set.
  task automatic t_recov(input int sb, input int fb, input int h, input logic dim);
    logic [31:0] d;
    int n;
    int lo;
    lo = (h > RCY) ? h : RCY;
    sense[sb] <= 1'b1;
    if (dim) bright <= 1'b0;
    tick(h);
    sense[sb] <= 1'b0;
    tick(1);
    chk("power off", 1'b0, pwr);
    if (dim) begin
      tick(RCY + 20);
      chk("dim holds off", 1'b0, pwr);
      bright <= 1'b1;
    end
    for (n = h + 1; n < 400 && pwr !== 1'b1; n++) tick(1);
    if (!dim) chk("recovery span", 1'b1, n >= lo - 2 && n <= lo + RCY + 8);
    chk("irq", 1'b1, irq);
    bus(1'b0, bfs_pkg::ADDR_STATUS, '0, d);
    chk("status", 32'h1 << fb, d);
    bus(1'b0, bfs_pkg::ADDR_STATE, '0, d);
    chk("state", {29'h0, bfs_pkg::ST_RUN}, d);
  endtask : t_recov

  // Feedback under level: a short dip is ignored, a long one trips.
  task automatic t_fb();
    logic [31:0] d;
    sense[0] <= 1'b1;
    tick(BOC - 5);
    sense[0] <= 1'b0;
    tick(3);
    chk("short dip", 1'b1, pwr);
    sense[0] <= 1'b1;
    wait_pwr(1'b0);
    sense[0] <= 1'b0;
    tick(3);
    chk("irq", 1'b1, irq);
    bus(1'b0, bfs_pkg::ADDR_STATUS, '0, d);
    chk("status", 32'h0000_0400, d);
    wait_pwr(1'b1);
  endtask : t_fb

  // Low over-voltage pauses switching only and never interrupts.
  task automatic t_ovlow();
    logic [31:0] d;
    sense[2] <= 1'b1;
    tick(4);
    chk("boost paused", 1'b0, bsw);
    chk("still on", 1'b1, pwr);
    chk("no irq", 1'b0, irq);
    sense[2] <= 1'b0;
    tick(4);
    chk("boost resumed", 1'b1, bsw);
    bus(1'b0, bfs_pkg::ADDR_STATUS, '0, d);
    chk("status", 32'h0000_0100, d);
  endtask : t_ovlow

  // A masked flag stays set silently and interrupts once unmasked.
  task automatic t_crc_mask();
    logic [31:0] d;
    bus(1'b1, bfs_pkg::ADDR_MASK, '0, d);
    sense[3] <= 1'b1;
    tick(1);
    sense[3] <= 1'b0;
    tick(4);
    chk("masked irq", 1'b0, irq);
    chk("still on", 1'b1, pwr);
    bus(1'b1, bfs_pkg::ADDR_MASK, 32'h0000_3FFF, d);
    tick(4);
    chk("irq", 1'b1, irq);
    bus(1'b0, bfs_pkg::ADDR_STATUS, '0, d);
    chk("status", 32'h0000_0080, d);
    tick(3);
    chk("irq released", 1'b0, irq);
  endtask : t_crc_mask

  // Sync clock lost: internal clock, spread spectrum follows the sync level.
  task automatic t_clk();
    logic [31:0] d;
    sync_in <= 1'b1;
    sense[4] <= 1'b1;
    tick(4);
    chk("internal clk", 1'b1, iclk);
    chk("irq", 1'b1, irq);
    chk("spread on", 1'b1, ss);
    sync_in <= 1'b0;
    tick(3);
    chk("spread off", 1'b0, ss);
    sense[4] <= 1'b0;
    bus(1'b0, bfs_pkg::ADDR_STATUS, '0, d);
    chk("status", 32'h0000_0040, d);
    chk("still on", 1'b1, pwr);
  endtask : t_clk

  // Missing pump parts: pump off, both pump flags, device keeps running.
  task automatic t_pump();
    logic [31:0] d;
    chk("pump on", 1'b1, cpo);
    sense[5] <= 1'b1;
    tick(4);
    chk("pump off", 1'b0, cpo);
    chk("still on", 1'b1, pwr);
    chk("irq", 1'b1, irq);
    sense[5] <= 1'b0;
    bus(1'b0, bfs_pkg::ADDR_STATUS, '0, d);
    chk("status", 32'h0000_0030, d);
    bus(1'b0, bfs_pkg::ADDR_CTRL, '0, d);
    chk("ctrl", 32'h0000_0007, d);
  endtask : t_pump

  // ****************************************
  // Main sequence
  // ****************************************
  // Inputs start at rest with every resistor reported bad.
  initial begin
    sys_rst_in = 1'b1;
    sense = '0;
    {sync_in, en, bright, init_done, sv, mv, bv, dv, msel} = '0;
    sch = 3'h2;
    scur = 8'h64;
    madr = 7'h3B;
    bf = 12'h3E8;
    df = 12'h0C8;
    tick(6);
    sys_rst_in <= 1'b0;
    t_reset();
    t_init();
    t_standby(10, bfs_pkg::B_IN_LOW);
    t_standby(9, bfs_pkg::B_IN_HIGH);
    t_standby(8, bfs_pkg::B_CORE_LOW);
    t_recov(7, bfs_pkg::B_IN_OC, 1, 1'b0);
    t_recov(6, bfs_pkg::B_CP, 1, 1'b1);
    t_recov(1, bfs_pkg::B_OV_HIGH, RCY + 30, 1'b0);
    t_fb();
    t_ovlow();
    t_crc_mask();
    t_clk();
    t_pump();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
